// ### common/macro_decoder_pkg.sv
// constants, types and settings for the drive input macro decoder
package macro_decoder_pkg;

  localparam int unsigned NUM_DI       = 4;
  localparam int unsigned SPEED_W      = 16;
  localparam int unsigned MACRO_W      = 5;
  localparam int unsigned DEBOUNCE_NS  = 5000000;
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;

  // terminal indexes
  localparam int unsigned DI1 = 0;
  localparam int unsigned DI2 = 1;
  localparam int unsigned DI3 = 2;
  localparam int unsigned DI4 = 3;

  // control source codes
  localparam logic [3:0] SRC_TERMINAL = 4'h0;
  localparam logic [3:0] SRC_KEYPAD_A = 4'h1;
  localparam logic [3:0] SRC_KEYPAD_B = 4'h2;
  localparam logic [3:0] SRC_PI_A     = 4'h5;
  localparam logic [3:0] SRC_PI_B     = 4'h6;

  // trip indication per analog-2 format
  localparam logic [3:0] AI2_FMT_THERM = 4'h6;

  typedef enum logic [2:0] {
    REF_ANALOG1 = 3'b000,
    REF_ANALOG2 = 3'b001,
    REF_PRESET  = 3'b010,
    REF_FIELDBUS = 3'b011,
    REF_KEYPAD  = 3'b100,
    REF_FIXED   = 3'b101
  } ref_sel_t;

  typedef enum logic [1:0] {
    ST_STOPPED  = 2'b00,
    ST_RUNNING  = 2'b01,
    ST_FASTSTOP = 2'b10,
    ST_TRIPPED  = 2'b11
  } run_state_t;

  typedef struct packed {
    logic [SPEED_W-1:0] analog1;
    logic [SPEED_W-1:0] analog2;
    logic [SPEED_W-1:0] fieldbus;
    logic [SPEED_W-1:0] keypad;
  } ref_sources_t;

  typedef struct packed {
    logic [SPEED_W-1:0] p1;
    logic [SPEED_W-1:0] p2;
    logic [SPEED_W-1:0] p3;
    logic [SPEED_W-1:0] p4;
  } presets_t;

  typedef struct packed {
    logic       run;
    logic       reverse;
    logic       fast_stop;
    logic       trip;
    logic       trip_thermistor;
  } drive_cmd_t;

endpackage

// ### src/input_conditioner.sv
// synchroniser, debouncer and edge detector for one terminal
module input_conditioner #(
  parameter int unsigned DEBOUNCE_CYC = 500000
) (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic srst_in,
  // terminal
  input  wire logic raw_in,
  // conditioned outputs
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);

  localparam int unsigned CNT_W = $clog2(DEBOUNCE_CYC + 1);

  logic             sync1_ff;
  logic             sync2_ff;
  logic             level_ff;
  logic             rise_ff;
  logic             fall_ff;
  logic [CNT_W-1:0] cnt_ff;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // level accepted only after stable for the debounce time
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cnt_ff   <= '0;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end else begin
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
      if (sync2_ff == level_ff) begin
        cnt_ff <= '0;
      end else if (cnt_ff == CNT_W'(DEBOUNCE_CYC - 1)) begin
        cnt_ff   <= '0;
        level_ff <= sync2_ff;
        rise_ff  <= sync2_ff;
        fall_ff  <= ~sync2_ff;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign level_out = level_ff;
  assign rise_out  = rise_ff;
  assign fall_out  = fall_ff;

endmodule

// ### src/drive_input_macro_decoder.sv
// terminal macro decoder producing drive run, direction, stop and reference commands
module drive_input_macro_decoder
  import macro_decoder_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = macro_decoder_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic                                 clock_in,
  input  wire logic                                 srst_in,
  // terminals
  input  wire logic [macro_decoder_pkg::NUM_DI-1:0] terminal_in,
  input  wire logic                                 enable_in,
  // settings
  input  wire logic [macro_decoder_pkg::MACRO_W-1:0] macro_select_in,
  input  wire logic [3:0]                           control_source_in,
  input  wire logic                                 auto_start_in,
  input  wire logic                                 keypad_needs_start_in,
  input  wire logic [3:0]                           analog_in2_format_in,
  // keypad and fieldbus commands
  input  wire logic                                 keypad_start_in,
  input  wire logic                                 keypad_stop_in,
  input  wire logic                                 fieldbus_start_in,
  input  wire logic                                 fieldbus_stop_in,
  input  wire logic                                 fieldbus_reverse_in,
  input  wire logic                                 trip_reset_in,
  // reference sources
  input  wire macro_decoder_pkg::ref_sources_t      ref_sources_in,
  input  wire macro_decoder_pkg::presets_t          presets_in,
  // outputs to motor control core
  output macro_decoder_pkg::drive_cmd_t             drive_cmd_out,
  output logic [macro_decoder_pkg::SPEED_W-1:0]     speed_reference_out,
  output logic                                      fire_mode_out
);

  import macro_decoder_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // terminal conditioning

  logic [NUM_DI-1:0] lvl;
  logic [NUM_DI-1:0] rise;
  logic [NUM_DI-1:0] fall;
  logic              en_lvl;
  logic              en_rise;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DI; gi++) begin : g_cond
      input_conditioner #(
        .DEBOUNCE_CYC (DEBOUNCE_CYC)
      ) u_cond (
        .clock_in  (clock_in),
        .srst_in   (srst_in),
        .raw_in    (terminal_in[gi]),
        .level_out (lvl[gi]),
        .rise_out  (rise[gi]),
        .fall_out  (fall[gi])
      );
    end
  endgenerate

  input_conditioner #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_enable (
    .clock_in  (clock_in),
    .srst_in   (srst_in),
    .raw_in    (enable_in),
    .level_out (en_lvl),
    .rise_out  (en_rise),
    .fall_out  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [SPEED_W-1:0] preset_pick(input logic b0, input logic b1,
                                                      input presets_t p);
    logic [SPEED_W-1:0] r;
    r = p.p1;
    case ({b1, b0})
      2'b00:   r = p.p1;
      2'b01:   r = p.p2;
      2'b10:   r = p.p3;
      2'b11:   r = p.p4;
      default: r = p.p1;
    endcase
    return r;
  endfunction

  logic is_keypad;
  logic is_terminal;
  assign is_keypad   = (control_source_in == SRC_KEYPAD_A) ||
                       (control_source_in == SRC_KEYPAD_B);
  assign is_terminal = (control_source_in == SRC_TERMINAL) ||
                       (control_source_in == SRC_PI_A) ||
                       (control_source_in == SRC_PI_B);

  ////////////////////////////////////////////////////////////////////////////
  // macro decode (terminal mode)

  logic       run_level;     // level that must hold for running
  logic       start_ev;      // momentary start event
  logic       start_rev;     // direction attached to start event
  logic       stop_ev;
  logic       fstop_ev;
  logic       trip_ev;
  logic       rev_level;
  logic       fire;
  logic       up_ev;
  logic       down_ev;
  logic       edge_mode;
  ref_sel_t   ref_sel;
  logic       pre_b0;
  logic       pre_b1;
  logic [SPEED_W-1:0] fixed_ref;

  always_comb begin
    run_level = 1'b0;
    start_ev  = 1'b0;
    start_rev = 1'b0;
    stop_ev   = 1'b0;
    fstop_ev  = 1'b0;
    trip_ev   = 1'b0;
    rev_level = 1'b0;
    fire      = 1'b0;
    up_ev     = 1'b0;
    down_ev   = 1'b0;
    edge_mode = 1'b0;
    ref_sel   = REF_ANALOG1;
    pre_b0    = 1'b0;
    pre_b1    = 1'b0;
    fixed_ref = presets_in.p1;
    case (macro_select_in)
      5'h00: begin
        run_level = lvl[DI1];
        rev_level = lvl[DI2];
        ref_sel   = lvl[DI3] ? REF_FIXED : REF_ANALOG1;
      end
      5'h01: begin
        run_level = lvl[DI1];
        ref_sel   = lvl[DI2] ? REF_PRESET : REF_ANALOG1;
        pre_b0    = lvl[DI3];
      end
      5'h02: begin
        run_level = lvl[DI1];
        ref_sel   = REF_PRESET;
        pre_b0    = lvl[DI2];
        pre_b1    = lvl[DI3];
      end
      5'h03: begin
        run_level = lvl[DI1];
        ref_sel   = lvl[DI2] ? REF_FIXED : REF_ANALOG1;
        trip_ev   = fall[DI3];
      end
      5'h04: begin
        run_level = lvl[DI1];
        ref_sel   = lvl[DI2] ? REF_ANALOG2 : REF_ANALOG1;
      end
      5'h05, 5'h07: begin
        run_level = lvl[DI1] ^ lvl[DI2];
        rev_level = lvl[DI2];
        fstop_ev  = lvl[DI1] & lvl[DI2] & (rise[DI1] | rise[DI2]);
        if (macro_select_in == 5'h05) begin
          ref_sel = lvl[DI3] ? REF_FIXED : REF_ANALOG1;
        end else begin
          trip_ev = fall[DI3];
        end
      end
      5'h06: begin
        run_level = lvl[DI1];
        rev_level = lvl[DI2];
        trip_ev   = fall[DI3];
      end
      5'h08: begin
        run_level = lvl[DI1];
        rev_level = lvl[DI2];
        ref_sel   = REF_PRESET;
        pre_b0    = lvl[DI3];
        pre_b1    = lvl[DI4];
      end
      5'h0a: begin
        edge_mode = 1'b1;
        start_ev  = rise[DI1] & lvl[DI2];
        stop_ev   = fall[DI2];
        ref_sel   = lvl[DI3] ? REF_FIXED : REF_ANALOG1;
      end
      5'h0b, 5'h0d: begin
        edge_mode = 1'b1;
        // both starts together act as fast stop
        fstop_ev  = lvl[DI1] & lvl[DI3] & (rise[DI1] | rise[DI3]);
        start_ev  = (rise[DI1] ^ rise[DI3]) & lvl[DI2] & ~(lvl[DI1] & lvl[DI3]);
        start_rev = rise[DI3];
        stop_ev   = fall[DI2];
        if (macro_select_in == 5'h0d) begin
          ref_sel = lvl[DI4] ? REF_FIXED : REF_KEYPAD;
        end
      end
      5'h0c: begin
        run_level = lvl[DI1];
        fstop_ev  = fall[DI2];
        ref_sel   = lvl[DI3] ? REF_FIXED : REF_ANALOG1;
      end
      5'h0e: begin
        run_level = lvl[DI1];
        trip_ev   = fall[DI3];
        ref_sel   = REF_PRESET;
        pre_b0    = lvl[DI2];
        pre_b1    = lvl[DI4];
      end
      5'h0f, 5'h10, 5'h11, 5'h12: begin
        run_level = lvl[DI1];
        fire      = lvl[DI3];
        ref_sel   = REF_FIXED;
        fixed_ref = presets_in.p4;
        if (macro_select_in == 5'h0f) begin
          ref_sel = lvl[DI2] ? REF_ANALOG1 : REF_FIXED;
        end else if (macro_select_in == 5'h10) begin
          fixed_ref = lvl[DI2] ? presets_in.p2 : presets_in.p4;
          rev_level = lvl[DI4];
        end else if (macro_select_in == 5'h11) begin
          ref_sel = REF_PRESET;
          pre_b0  = lvl[DI2];
          pre_b1  = lvl[DI4];
        end else begin
          rev_level = lvl[DI2];
          ref_sel   = REF_PRESET;
          pre_b0    = 1'b1;
          pre_b1    = 1'b1;
        end
      end
      5'h13: begin
        // speed trim by momentary inputs
        run_level = lvl[DI1];
        up_ev     = rise[DI2];
        down_ev   = rise[DI3];
        ref_sel   = REF_FIELDBUS;
      end
      default: begin
        run_level = lvl[DI1];
        ref_sel   = REF_ANALOG1;
      end
    endcase
    if (is_keypad) begin
      ref_sel = REF_KEYPAD;
    end else if (!is_terminal) begin
      ref_sel = REF_FIELDBUS;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run sequencing

  run_state_t state_ff;
  logic       rev_ff;
  logic       power_up_ff;
  logic       thermistor_ff;
  logic       want_run;
  logic       want_start;
  logic       stop_req;

  always_comb begin
    want_start = 1'b0;
    want_run   = 1'b0;
    stop_req   = stop_ev | keypad_stop_in;
    if (is_keypad) begin
      want_run   = en_lvl;
      want_start = en_lvl & ((~keypad_needs_start_in & en_rise) | keypad_start_in);
    end else if (is_terminal) begin
      want_run   = edge_mode ? 1'b1 : run_level;
      want_start = edge_mode ? start_ev : run_level;
    end else begin
      want_run   = en_lvl & ~fieldbus_stop_in;
      want_start = en_lvl & fieldbus_start_in;
    end
    if (power_up_ff && auto_start_in && en_lvl) begin
      want_start = 1'b1;
    end
    if (fire) begin
      want_run   = 1'b1;
      want_start = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      power_up_ff <= 1'b1;
    end else if (en_lvl || state_ff != ST_STOPPED) begin
      power_up_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state_ff      <= ST_STOPPED;
      thermistor_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_STOPPED, ST_RUNNING: begin
          if (trip_ev) begin
            state_ff      <= ST_TRIPPED;
            thermistor_ff <= (analog_in2_format_in == AI2_FMT_THERM);
          end else if (fstop_ev && !fire) begin
            state_ff <= ST_FASTSTOP;
          end else if ((stop_req || !want_run) && !fire) begin
            state_ff <= ST_STOPPED;
          end else if (want_start || (state_ff == ST_RUNNING)) begin
            state_ff <= ST_RUNNING;
          end
        end
        ST_FASTSTOP: begin
          if (trip_ev) begin
            state_ff      <= ST_TRIPPED;
            thermistor_ff <= (analog_in2_format_in == AI2_FMT_THERM);
          end else begin
            state_ff <= ST_STOPPED;
          end
        end
        ST_TRIPPED: begin
          // indication goes with the trip; a new trip edge keeps both set
          if (trip_reset_in && !trip_ev) begin
            state_ff      <= fire ? ST_RUNNING : ST_STOPPED;
            thermistor_ff <= 1'b0;
          end
        end
        default: state_ff <= ST_STOPPED;
      endcase
    end
  end

  // direction register
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rev_ff <= 1'b0;
    end else if (!is_terminal) begin
      rev_ff <= fieldbus_reverse_in;
    end else if (edge_mode) begin
      if (start_ev) begin
        rev_ff <= start_rev;
      end
    end else begin
      rev_ff <= rev_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // speed reference

  logic [SPEED_W-1:0] trim_ff;
  logic [SPEED_W-1:0] ref_ff;
  logic [SPEED_W-1:0] nxt_ref;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      trim_ff <= '0;
    end else if (up_ev && !down_ev) begin
      trim_ff <= trim_ff + presets_in.p1;
    end else if (down_ev && !up_ev) begin
      trim_ff <= (trim_ff > presets_in.p1) ? trim_ff - presets_in.p1 : '0;
    end
  end

  always_comb begin
    case (ref_sel)
      REF_ANALOG1:  nxt_ref = ref_sources_in.analog1;
      REF_ANALOG2:  nxt_ref = ref_sources_in.analog2;
      REF_PRESET:   nxt_ref = preset_pick(pre_b0, pre_b1, presets_in);
      REF_FIELDBUS: nxt_ref = (macro_select_in == 5'h13) ? trim_ff : ref_sources_in.fieldbus;
      REF_KEYPAD:   nxt_ref = ref_sources_in.keypad;
      REF_FIXED:    nxt_ref = fixed_ref;
      default:      nxt_ref = ref_sources_in.analog1;
    endcase
    if (fire) begin
      nxt_ref = presets_in.p4;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ref_ff <= '0;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  assign drive_cmd_out.run             = (state_ff == ST_RUNNING);
  assign drive_cmd_out.reverse         = rev_ff;
  assign drive_cmd_out.fast_stop       = (state_ff == ST_FASTSTOP);
  assign drive_cmd_out.trip            = (state_ff == ST_TRIPPED);
  assign drive_cmd_out.trip_thermistor = thermistor_ff;
  assign speed_reference_out           = ref_ff;
  assign fire_mode_out                 = fire;

endmodule

// ### bench/drive_input_macro_decoder_sva.sv
// assertion checker on the macro decoder top ports
module drive_input_macro_decoder_sva
  import macro_decoder_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYC = 4
) (
  // clock and reset
  input wire logic                                  clock_in,
  input wire logic                                  srst_in,
  // watched inputs
  input wire logic [macro_decoder_pkg::MACRO_W-1:0] macro_select_in,
  input wire logic                                  trip_reset_in,
  input wire macro_decoder_pkg::presets_t           presets_in,
  // watched outputs
  input wire macro_decoder_pkg::drive_cmd_t         drive_cmd_out,
  input wire logic [macro_decoder_pkg::SPEED_W-1:0] speed_reference_out,
  input wire logic                                  fire_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (srst_in);

  a_reset_clears_out: assert property (
    $fell(srst_in) |-> drive_cmd_out == '0 && speed_reference_out == '0)
    else $error("outputs not cleared by reset");
  a_fast_stop_pulse: assert property (
    drive_cmd_out.fast_stop |=> !drive_cmd_out.fast_stop && !drive_cmd_out.run)
    else $error("fast stop not a single pulse into stop");
  a_state_one_hot: assert property (
    $onehot0({drive_cmd_out.run, drive_cmd_out.fast_stop, drive_cmd_out.trip}))
    else $error("run, fast stop and trip overlap");
  a_trip_holds_on: assert property (
    drive_cmd_out.trip && !trip_reset_in |=> drive_cmd_out.trip)
    else $error("trip dropped without reset");
  a_thermistor_with_trip: assert property (
    drive_cmd_out.trip_thermistor |-> drive_cmd_out.trip)
    else $error("trip indication without trip");
  a_fire_macro_only: assert property (
    fire_mode_out |-> macro_select_in inside {[5'h0f:5'h12]})
    else $error("fire mode outside fire macros");
  a_fire_runs_motor: assert property (
    fire_mode_out |=> drive_cmd_out.run || drive_cmd_out.trip)
    else $error("fire mode not running");
  a_fire_uses_p4: assert property (
    fire_mode_out && !drive_cmd_out.trip |=> speed_reference_out == $past(presets_in.p4))
    else $error("fire mode reference not fourth preset");
endmodule

// ### bench/contact_bank.sv
// switch contact model: each change chatters before settling
module contact_bank (
  // clock
  input  wire logic       clock_in,
  // wanted contact states
  input  wire logic [3:0] want_in,
  // terminal levels
  output logic      [3:0] terminal_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last_ff = 4'h0;
  logic [3:0] chg_ff  = 4'h0;
  logic [1:0] cnt_ff  = 2'h0;

  // chatter lasts three cycles, shorter than the debounce window
  always @(posedge clock_in) begin
    if (want_in != last_ff) begin
      chg_ff  <= want_in ^ last_ff;
      last_ff <= want_in;
      cnt_ff  <= 2'h3;
    end else if (cnt_ff != 2'h0) begin
      cnt_ff <= cnt_ff - 2'h1;
    end
  end
  assign terminal_out = cnt_ff[0] ? (last_ff ^ chg_ff) : last_ff;
endmodule

// ### bench/drive_input_macro_decoder_test.sv
// self-checking bench for the drive input macro decoder
module drive_input_macro_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import macro_decoder_pkg::*;

  typedef struct {
    logic [4:0]  mac;
    logic [3:0]  di;
    logic        run;
    logic        rev;
    logic [15:0] spd;
  } row_t;

  logic         clock_in  = 1'b0;
  logic         srst_in   = 1'b1;
  logic [3:0]   want      = 4'h0;
  logic [3:0]   terminal;
  logic         enable    = 1'b1;
  logic         auto_start = 1'b0;
  logic         kpd_wait  = 1'b1;
  logic [4:0]   macro_sel = 5'h00;
  logic [3:0]   ctrl_src  = 4'h0;
  logic [3:0]   ai2_fmt   = 4'h0;
  logic         kpd_start = 1'b0;
  logic         kpd_stop  = 1'b0;
  logic         fb_start  = 1'b0;
  logic         trip_rst  = 1'b0;
  ref_sources_t refs      = {16'h1111, 16'h2222, 16'h3333, 16'h4444};
  presets_t     pres      = {16'h0101, 16'h0202, 16'h0303, 16'h0404};
  drive_cmd_t   cmd;
  logic [15:0]  speed;
  logic         fire;
  int           n_fail    = 0;
  int           compares  = 0;
  int           n_fast    = 0;
  int           n0;
  row_t         rows [19];

  contact_bank i_contact_bank (.clock_in(clock_in), .want_in(want), .terminal_out(terminal));
  drive_input_macro_decoder #(.DEBOUNCE_CYC(4)) i_drive_input_macro_decoder (
    .clock_in(clock_in), .srst_in(srst_in), .terminal_in(terminal), .enable_in(enable),
    .macro_select_in(macro_sel), .control_source_in(ctrl_src), .auto_start_in(auto_start),
    .keypad_needs_start_in(kpd_wait), .analog_in2_format_in(ai2_fmt),
    .keypad_start_in(kpd_start), .keypad_stop_in(kpd_stop), .fieldbus_start_in(fb_start),
    .fieldbus_stop_in(1'b0), .fieldbus_reverse_in(1'b0), .trip_reset_in(trip_rst),
    .ref_sources_in(refs), .presets_in(pres), .drive_cmd_out(cmd),
    .speed_reference_out(speed), .fire_mode_out(fire));

  initial begin
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (cmd.fast_stop === 1'b1) n_fast <= n_fast + 1;
  end

  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t: %s", $time, what);
    end
  endtask
  // settle time covers chatter, sync, debounce, state and reference stages
  task automatic apply(input logic [4:0] m, input logic [3:0] d);
    @(posedge clock_in);
    macro_sel <= m;
    want <= d;
    wait_cyc(20);
  endtask
  // momentary contact change, held past the debounce window
  task automatic pulse(input logic [3:0] m);
    @(posedge clock_in);
    want <= want ^ m;
    wait_cyc(12);
    @(posedge clock_in);
    want <= want ^ m;
    wait_cyc(20);
  endtask

  initial begin
    #200us;
    n_fail++;
    $display("ERROR %0t: run hung", $time);
    test_done();
  end

  initial begin
    rows = '{'{5'h00, 4'h1, 1'b1, 1'b0, refs.analog1}, '{5'h00, 4'h3, 1'b1, 1'b1, refs.analog1},
             '{5'h00, 4'h7, 1'b1, 1'b1, pres.p1},      '{5'h00, 4'h0, 1'b0, 1'b0, refs.analog1},
             '{5'h01, 4'h3, 1'b1, 1'b0, pres.p1},      '{5'h01, 4'h7, 1'b1, 1'b0, pres.p2},
             '{5'h02, 4'h7, 1'b1, 1'b0, pres.p4},      '{5'h02, 4'h3, 1'b1, 1'b0, pres.p2},
             '{5'h04, 4'h3, 1'b1, 1'b0, refs.analog2}, '{5'h05, 4'h2, 1'b1, 1'b1, refs.analog1},
             '{5'h05, 4'h1, 1'b1, 1'b0, refs.analog1}, '{5'h0f, 4'h4, 1'b1, 1'b0, pres.p4},
             '{5'h08, 4'hd, 1'b1, 1'b0, pres.p4},      '{5'h06, 4'h7, 1'b1, 1'b1, refs.analog1},
             '{5'h07, 4'h6, 1'b1, 1'b1, refs.analog1}, '{5'h0e, 4'hf, 1'b1, 1'b0, pres.p4},
             '{5'h10, 4'h3, 1'b1, 1'b0, pres.p2},      '{5'h11, 4'h9, 1'b1, 1'b0, pres.p3},
             '{5'h12, 4'h3, 1'b1, 1'b1, pres.p4}};
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    #1;
    check(cmd === '0 && speed === 16'h0000, "outputs after reset");
    wait_cyc(1);
    check(cmd === '0 && speed === refs.analog1, "reference one cycle after reset");
    $display("test reset done");
    apply(5'h13, 4'h0);
    pulse(4'h2);
    pulse(4'h2);
    check(speed === pres.p1 + pres.p1, "speed up twice");
    pulse(4'h4);
    check(speed === pres.p1, "speed down once");
    pulse(4'h4);
    pulse(4'h4);
    check(speed === 16'h0000, "speed floor");
    $display("test speed trim done");
    foreach (rows[i]) begin
      apply(rows[i].mac, rows[i].di);
      check(cmd.run === rows[i].run, "row run");
      check(speed === rows[i].spd, "row reference");
      check(fire === (rows[i].mac == 5'h0f), "row fire mode");
      if (rows[i].run) check(cmd.reverse === rows[i].rev, "row direction");
    end
    $display("test rows done");
    for (int f = 0; f < 2; f++) begin
      apply(5'h03, 4'h4);
      apply(5'h03, 4'h5);
      check(cmd.run === 1'b1, "run before trip");
      @(posedge clock_in);
      ai2_fmt <= f ? 4'h0 : AI2_FMT_THERM;
      pulse(4'h4);
      check(cmd.trip === 1'b1 && cmd.run === 1'b0, "external trip");
      check(cmd.trip_thermistor === (f == 0), "trip indication");
      @(posedge clock_in);
      trip_rst <= 1'b1;
      @(posedge clock_in);
      trip_rst <= 1'b0;
      wait_cyc(3);
      check(cmd.trip === 1'b0 && cmd.trip_thermistor === 1'b0, "trip cleared");
    end
    $display("test trip done");
    apply(5'h0c, 4'h3);
    n0 = n_fast;
    pulse(4'h2);
    check(n_fast == n0 + 1, "one fast stop pulse");
    apply(5'h0c, 4'h2);
    apply(5'h0a, 4'h2);
    check(cmd.run === 1'b0, "edge macro idle");
    pulse(4'h1);
    check(cmd.run === 1'b1, "edge start");
    pulse(4'h2);
    check(cmd.run === 1'b0, "edge stop");
    $display("test edges done");
    apply(5'h00, 4'h0);
    @(posedge clock_in);
    ctrl_src <= 4'h3;
    enable <= 1'b0;
    wait_cyc(20);
    @(posedge clock_in);
    fb_start <= 1'b1;
    wait_cyc(20);
    check(cmd.run === 1'b0, "fieldbus start without enable");
    check(speed === refs.fieldbus, "fieldbus reference");
    @(posedge clock_in);
    fb_start <= 1'b0;
    ctrl_src <= 4'h1;
    wait_cyc(2);
    @(posedge clock_in);
    enable <= 1'b1;
    wait_cyc(20);
    check(cmd.run === 1'b0, "keypad waits for start key");
    @(posedge clock_in);
    kpd_start <= 1'b1;
    @(posedge clock_in);
    kpd_start <= 1'b0;
    wait_cyc(5);
    check(cmd.run === 1'b1, "keypad start key");
    check(speed === refs.keypad, "keypad reference");
    @(posedge clock_in);
    kpd_stop <= 1'b1;
    @(posedge clock_in);
    kpd_stop <= 1'b0;
    wait_cyc(5);
    check(cmd.run === 1'b0, "keypad stop key");
    $display("test control sources done");
    @(posedge clock_in);
    kpd_wait <= 1'b0;
    enable <= 1'b0;
    wait_cyc(20);
    @(posedge clock_in);
    enable <= 1'b1;
    wait_cyc(20);
    check(cmd.run === 1'b1, "enable alone starts keypad drive");
    @(posedge clock_in);
    kpd_wait <= 1'b1;
    auto_start <= 1'b1;
    srst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    #1;
    check(cmd === '0 && speed === 16'h0000, "outputs after second reset");
    wait_cyc(20);
    check(cmd.run === 1'b1, "auto start after power-up");
    $display("test power-up done");
    test_done();
  end
endmodule

bind drive_input_macro_decoder drive_input_macro_decoder_sva #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) i_sva (
  .clock_in(clock_in), .srst_in(srst_in), .macro_select_in(macro_select_in),
  .trip_reset_in(trip_reset_in), .presets_in(presets_in), .drive_cmd_out(drive_cmd_out),
  .speed_reference_out(speed_reference_out), .fire_mode_out(fire_mode_out));
